// file: rtl/cio_top.sv
`include "cio_consts.svh"

// Functional notes
// - every pad is in exactly one of input, output or alternate mode at a time.
// - an input-mode pad is read-only and reads the level on the pad.
// - an output-mode pad drives the written level, and a query returns that value.
// - an alternate-mode pad is driven or sampled by its internal function, not the user path.
// - the jam flag pad offers input, output and jamming detect output.
// - the transmit inhibit pad offers input, output and transmission control input.
// - the transmit monitor pad offers input, output and transmit activity output.
// - the wake alert pad offers input, output and alarm output.
// - the tone pad offers input, output and square-wave buzzer output.
// - the four voice pads carry audio transmit, receive, frame sync and clock as alternate use.
// - every pad comes up in input mode after reset.
// - during reset the pads other than wake alert are undefined.
// - the wake alert pad is held high throughout reset.
// - in alternate mode a low transmit inhibit pad suppresses transmission.
// - the transmit monitor rises 300ms before the first burst and falls 500ms to 1s after the last.
// - the alarm output rises when the alarm starts and stays high until cleared.
module cio_top (
    input wire logic clock, // 20 MHz system clock
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [`CIO_NPADS-1:0] pad_i, // pad input levels
    output cio_pkg::cio_pad_drive_s pad_drv, // pad output levels and enables
    input wire logic [`CIO_NPADS-1:0] mode_wr, // pulse: load new mode for pad
    input wire logic [2*`CIO_NPADS-1:0] mode_wdata, // two bits per pad
    output logic [2*`CIO_NPADS-1:0] mode_q, // current mode per pad
    input wire logic [`CIO_NPADS-1:0] out_wr, // pulse: write output value
    input wire logic [`CIO_NPADS-1:0] out_wdata, // value to write
    output logic [`CIO_NPADS-1:0] out_q, // written output values
    output logic [`CIO_NPADS-1:0] in_level_q, // synchronised pad levels
    input wire logic jam_detect, // jamming detect from firmware
    input wire logic tx_request, // firmware wants to transmit
    output logic tx_enable_q, // transmit allowed now
    output logic tx_inhibited, // transmission held off by inhibit pad
    input wire logic alarm_start, // pulse: alarm begins
    input wire logic alarm_clear, // pulse: clearing command
    output logic alarm_q, // alarm output state
    input wire logic tone_on, // firmware buzzer request
    input wire logic [15:0] tone_half, // buzzer half period in cycles
    input wire logic voice_out_data, // audio transmit bit
    input wire logic voice_frame_sync, // audio frame sync
    input wire logic voice_clk, // audio bit clock
    output logic voice_in_data // synchronised audio receive bit
);
    import cio_pkg::*;

    localparam int unsigned LEAD_CYC = `CIO_MON_LEAD_CYC;
    localparam int unsigned TRAIL_CYC = `CIO_MON_TRAIL_CYC;

    logic rst_a_q;
    logic rst_n;
    logic [`CIO_NPADS-1:0] in_lvl;
    logic [2*`CIO_NPADS-1:0] mode_d;
    logic [`CIO_NPADS-1:0] out_d;
    logic [`CIO_NPADS-1:0] alt_o;
    logic [`CIO_NPADS-1:0] alt_oe;
    logic [`CIO_NPADS-1:0] drv_o_d;
    logic [`CIO_NPADS-1:0] drv_oe_d;
    cio_pad_drive_s drv_q;
    logic alarm_d;
    logic tone_wave;
    logic inhibit_n;
    cio_mon_e mon_q;
    cio_mon_e mon_d;
    logic [`CIO_CNT_W-1:0] mon_cnt_q;
    logic [`CIO_CNT_W-1:0] mon_cnt_d;
    logic tx_en_d;
    logic mon_out;

    // decode the mode field of one pad
    function automatic cio_mode_t pad_mode(input logic [2*`CIO_NPADS-1:0] m, input int idx);
        pad_mode = m[2*idx +: 2];
    endfunction : pad_mode

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    // every pad input is synchronised before anyone looks at it
    genvar gi;
    generate
        for (gi = 0; gi < `CIO_NPADS; gi++)
        begin : g_sync
            cio_sync u_sync (
                .clock(clock),
                .rst_n(rst_n),
                .pad_in(pad_i[gi]),
                .level_q(in_lvl[gi])
            );
        end
    endgenerate

    cio_tone u_tone (
        .clock(clock),
        .rst_n(rst_n),
        .enable(tone_on),
        .half_period(tone_half),
        .wave_q(tone_wave)
    );

    // mode and output registers; an unsupported code keeps the old mode
    always_comb
    begin
        mode_d = mode_q;
        out_d = out_q;
        for (int i = 0; i < `CIO_NPADS; i++)
        begin
            if (mode_wr[i] && (mode_wdata[2*i +: 2] != 2'h3))
            begin
                mode_d[2*i +: 2] = mode_wdata[2*i +: 2];
            end
            // writes are taken in any mode but drive only in output mode
            if (out_wr[i])
            begin
                out_d[i] = out_wdata[i];
            end
        end
    end

    // alarm latch: start wins over a clear in the same cycle
    always_comb
    begin
        alarm_d = alarm_q;
        if (alarm_clear)
        begin
            alarm_d = 1'b0;
        end
        if (alarm_start)
        begin
            alarm_d = 1'b1;
        end
    end

    // inhibit only counts when the pad is in its alternate mode
    assign inhibit_n = (pad_mode(mode_q, `CIO_PAD_INH) == `CIO_MODE_ALT) ? in_lvl[`CIO_PAD_INH] : 1'b1;
    assign tx_inhibited = ~inhibit_n;

    // transmit monitor: hold transmit back for the lead time so the pad is
    // already high 300ms before the first burst; trail keeps it high afterwards
    always_comb
    begin
        mon_d = mon_q;
        mon_cnt_d = mon_cnt_q;
        tx_en_d = 1'b0;
        case (mon_q)
            CIO_MON_IDLE:
            begin
                if (tx_request && inhibit_n)
                begin
                    mon_d = CIO_MON_LEAD;
                    mon_cnt_d = `CIO_CNT_W'(LEAD_CYC - 1);
                end
            end
            CIO_MON_LEAD:
            begin
                if (!tx_request || !inhibit_n)
                begin
                    mon_d = CIO_MON_TRAIL;
                    mon_cnt_d = `CIO_CNT_W'(TRAIL_CYC - 1);
                end
                else if (mon_cnt_q == '0)
                begin
                    mon_d = CIO_MON_ACTIVE;
                    tx_en_d = 1'b1;
                end
                else
                begin
                    mon_cnt_d = mon_cnt_q - `CIO_CNT_W'(1);
                end
            end
            CIO_MON_ACTIVE:
            begin
                if (tx_request && inhibit_n)
                begin
                    tx_en_d = 1'b1;
                end
                else
                begin
                    mon_d = CIO_MON_TRAIL;
                    mon_cnt_d = `CIO_CNT_W'(TRAIL_CYC - 1);
                end
            end
            CIO_MON_TRAIL:
            begin
                if (tx_request && inhibit_n)
                begin
                    mon_d = CIO_MON_ACTIVE;
                    tx_en_d = 1'b1;
                end
                else if (mon_cnt_q == '0)
                begin
                    mon_d = CIO_MON_IDLE;
                end
                else
                begin
                    mon_cnt_d = mon_cnt_q - `CIO_CNT_W'(1);
                end
            end
            default:
            begin
                mon_d = CIO_MON_IDLE;
            end
        endcase
    end

    assign mon_out = (mon_q != CIO_MON_IDLE);

    // alternate-function sources per pad; inputs-only functions leave oe low
    always_comb
    begin
        alt_o = '0;
        alt_oe = '0;
        alt_o[`CIO_PAD_JAM] = jam_detect;
        alt_oe[`CIO_PAD_JAM] = 1'b1;
        alt_o[`CIO_PAD_MON] = mon_out;
        alt_oe[`CIO_PAD_MON] = 1'b1;
        alt_o[`CIO_PAD_WAKE] = alarm_q;
        alt_oe[`CIO_PAD_WAKE] = 1'b1;
        alt_o[`CIO_PAD_TONE] = tone_wave;
        alt_oe[`CIO_PAD_TONE] = 1'b1;
        alt_o[`CIO_PAD_VOUT] = voice_out_data;
        alt_oe[`CIO_PAD_VOUT] = 1'b1;
        alt_o[`CIO_PAD_SYNC] = voice_frame_sync;
        alt_oe[`CIO_PAD_SYNC] = 1'b1;
        alt_o[`CIO_PAD_VCLK] = voice_clk;
        alt_oe[`CIO_PAD_VCLK] = 1'b1;
        // in alternate mode the inhibit and voice receive pads are sampled, not driven
    end

    // pad drive selection by mode; input mode releases the pad
    always_comb
    begin
        drv_o_d = '0;
        drv_oe_d = '0;
        for (int i = 0; i < `CIO_NPADS; i++)
        begin
            case (pad_mode(mode_q, i))
                `CIO_MODE_OUT:
                begin
                    drv_o_d[i] = out_q[i];
                    drv_oe_d[i] = 1'b1;
                end
                `CIO_MODE_ALT:
                begin
                    drv_o_d[i] = alt_o[i];
                    drv_oe_d[i] = alt_oe[i];
                end
                default:
                begin
                    drv_o_d[i] = 1'b0;
                    drv_oe_d[i] = 1'b0;
                end
            endcase
        end
    end

    // registers; wake alert pad driven high during reset, others released
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= '0;
            out_q <= '0;
            alarm_q <= 1'b0;
            mon_q <= CIO_MON_IDLE;
            mon_cnt_q <= '0;
            tx_enable_q <= 1'b0;
            drv_q.o <= `CIO_NPADS'(1) << `CIO_PAD_WAKE;
            drv_q.oe <= `CIO_NPADS'(1) << `CIO_PAD_WAKE;
            in_level_q <= '0;
            voice_in_data <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            out_q <= out_d;
            alarm_q <= alarm_d;
            mon_q <= mon_d;
            mon_cnt_q <= mon_cnt_d;
            tx_enable_q <= tx_en_d;
            drv_q.o <= drv_o_d;
            drv_q.oe <= drv_oe_d;
            in_level_q <= in_lvl;
            voice_in_data <= in_lvl[`CIO_PAD_VIN];
        end
    end

    assign pad_drv = drv_q;
endmodule : cio_top

// file: rtl/cio_consts.svh
`ifndef CIO_CONSTS_SVH
`define CIO_CONSTS_SVH

// pad indices within the pad vector
`define CIO_PAD_JAM 0
`define CIO_PAD_SYNC 1
`define CIO_PAD_VIN 2
`define CIO_PAD_INH 3
`define CIO_PAD_MON 4
`define CIO_PAD_WAKE 5
`define CIO_PAD_TONE 6
`define CIO_PAD_VOUT 7
`define CIO_PAD_VCLK 8
`define CIO_NPADS 9

// mode encodings
`define CIO_MODE_IN 2'h0
`define CIO_MODE_OUT 2'h1
`define CIO_MODE_ALT 2'h2

// clock rate and transmit-monitor timing
`define CIO_CLK_HZ 20000000
`define CIO_MON_LEAD_MS 300
`define CIO_MON_TRAIL_MIN_MS 500
`define CIO_MON_TRAIL_MAX_MS 1000
`define CIO_MON_LEAD_CYC ((`CIO_MON_LEAD_MS * (`CIO_CLK_HZ / 1000)))
`define CIO_MON_TRAIL_CYC ((`CIO_MON_TRAIL_MIN_MS * (`CIO_CLK_HZ / 1000)))
`define CIO_CNT_W 25

// tone divider default half period in cycles
`define CIO_TONE_HALF 10000

`endif

// file: rtl/cio_pkg.sv
`include "cio_consts.svh"

package cio_pkg;
    typedef logic [1:0] cio_mode_t;

    typedef struct packed {
        logic [`CIO_NPADS-1:0] o;
        logic [`CIO_NPADS-1:0] oe;
    } cio_pad_drive_s;

    typedef enum logic [1:0] {
        CIO_MON_IDLE,
        CIO_MON_LEAD,
        CIO_MON_ACTIVE,
        CIO_MON_TRAIL
    } cio_mon_e;
endpackage : cio_pkg

// file: rtl/cio_sync.sv
// three-flop pad synchroniser; value changes once stages two and three agree
module cio_sync (
    input wire logic clock, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic pad_in, // raw pad level
    output logic level_q // filtered synchronous level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_d;

    // accept new level only when the last two stages match
    always_comb
    begin
        level_d = (s2_q == s3_q) ? s3_q : level_q;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            s1_q <= pad_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end
endmodule : cio_sync

// file: rtl/cio_tone.sv
// square-wave source for the tone pad
module cio_tone (
    input wire logic clock, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic enable, // run the tone
    input wire logic [15:0] half_period, // half period in cycles, 0 treated as 1
    output logic wave_q // square wave
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic wave_d;

    // count down half periods, toggle at zero; idle low when disabled
    always_comb
    begin
        cnt_d = cnt_q;
        wave_d = wave_q;
        if (!enable)
        begin
            cnt_d = 16'h0000;
            wave_d = 1'b0;
        end
        else if (cnt_q == 16'h0000)
        begin
            cnt_d = (half_period == 16'h0000) ? 16'h0000 : half_period - 16'h0001;
            wave_d = ~wave_q;
        end
        else
        begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 16'h0000;
            wave_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            wave_q <= wave_d;
        end
    end
endmodule : cio_tone

// file: verif/cio_properties.sv
`include "cio_consts.svh"

// watches the pad block from its ports only
module cio_properties (
    input wire logic clock, // system clock
    input wire logic resetn, // reset, active low
    input wire cio_pkg::cio_pad_drive_s pad_drv, // pad drive
    input wire logic [2*`CIO_NPADS-1:0] mode_q, // modes
    input wire logic [`CIO_NPADS-1:0] out_q, // written values
    input wire logic jam_detect, // jam flag source
    input wire logic tx_request, // transmit wish
    input wire logic tx_enable_q, // transmit allowed
    input wire logic tx_inhibited, // inhibit active
    input wire logic alarm_start, // alarm begin
    input wire logic alarm_clear, // alarm clear
    input wire logic alarm_q // alarm state
);
    import cio_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // steps reused below
    sequence s_out_sel;
        mode_q[1:0] == `CIO_MODE_OUT;
    endsequence
    sequence s_alarm_held;
        alarm_q && !(alarm_clear && !alarm_start);
    endsequence
    a_wake_reset_high: assert property (disable iff (1'b0) !resetn |-> pad_drv.oe[5] && pad_drv.o[5])
        else $error("wake pad not high in reset");
    a_out_pad_drive: assert property (s_out_sel |=> pad_drv.oe[0] && pad_drv.o[0] == $past(out_q[0]))
        else $error("output pad level wrong");
    a_in_pad_free: assert property (mode_q[3:2] == `CIO_MODE_IN |=> !pad_drv.oe[1])
        else $error("input pad driven");
    a_jam_alt_follow: assert property (mode_q[1:0] == `CIO_MODE_ALT && $stable(jam_detect)
        |=> pad_drv.oe[0] && pad_drv.o[0] == $past(jam_detect))
        else $error("jam pad not following source");
    a_alarm_set: assert property (alarm_start |=> alarm_q)
        else $error("alarm not raised");
    a_alarm_kept: assert property (s_alarm_held |=> alarm_q)
        else $error("alarm dropped without clear");
    a_inhibit_stop: assert property (tx_inhibited |-> mode_q[7:6] == `CIO_MODE_ALT ##1 !tx_enable_q)
        else $error("transmit not held off");
    a_monitor_lead: assert property ($rose(tx_request) && mode_q[9:8] == `CIO_MODE_ALT && !tx_inhibited
        |-> ##[1:3] (pad_drv.oe[4] && pad_drv.o[4]))
        else $error("monitor pad did not rise");
endmodule : cio_properties

bind cio_top cio_properties i_props (.clock, .resetn, .pad_drv, .mode_q, .out_q, .jam_detect, .tx_request,
    .tx_enable_q, .tx_inhibited, .alarm_start, .alarm_clear, .alarm_q);

// file: verif/cio_pad_model.sv
`include "cio_consts.svh"

// application circuitry on the pads
module cio_pad_model (
    input wire logic clock, // system clock
    input wire cio_pkg::cio_pad_drive_s pad_drv, // module pad drive
    input wire logic [`CIO_NPADS-1:0] ext_en, // external driver on
    input wire logic [`CIO_NPADS-1:0] ext_val, // external driver level
    output logic [`CIO_NPADS-1:0] pad_lvl // resolved pad levels
);
    import cio_pkg::*;
    logic flip_q = 1'b0;
    // a floating line toggles so no stale level can be read
    always_ff @(posedge clock)
        flip_q <= ~flip_q;
    // module drive first, then application, then pull-up or float
    always_comb
    begin
        for (int i = 0; i < `CIO_NPADS; i++)
        begin
            if (pad_drv.oe[i])
                pad_lvl[i] = pad_drv.o[i];
            else if (ext_en[i])
                pad_lvl[i] = ext_val[i]; // application drives ext_val where enabled
            else
                pad_lvl[i] = (i == `CIO_PAD_INH) ? 1'b1 : flip_q;
        end
    end
endmodule : cio_pad_model

// file: verif/test_configurable_io_pad_modes.sv
`include "cio_consts.svh"

module test_configurable_io_pad_modes;
    timeunit 1ns;
    timeprecision 1ns;
    import cio_pkg::*;
    logic clock, resetn, jam_detect, tx_request, tx_enable_q, tx_inhibited, alarm_start, alarm_clear, alarm_q;
    logic tone_on, voice_out_data, voice_frame_sync, voice_clk, voice_in_data;
    logic [15:0] tone_half;
    logic [`CIO_NPADS-1:0] pad_i, mode_wr, out_wr, out_wdata, out_q, in_level_q, ext_en, ext_val;
    logic [2*`CIO_NPADS-1:0] mode_wdata, mode_q;
    cio_pad_drive_s pad_drv;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    cio_top i_dut (.clock, .resetn, .pad_i, .pad_drv, .mode_wr, .mode_wdata, .mode_q, .out_wr, .out_wdata,
        .out_q, .in_level_q, .jam_detect, .tx_request, .tx_enable_q, .tx_inhibited, .alarm_start,
        .alarm_clear, .alarm_q, .tone_on, .tone_half, .voice_out_data, .voice_frame_sync, .voice_clk,
        .voice_in_data);
    cio_pad_model i_pads (.clock, .pad_drv, .ext_en, .ext_val, .pad_lvl(pad_i));

    // 50 ns clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // hang guard, well above the expected run
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    // same mode code to every pad, then let the drive settle
    task automatic set_all(input logic [1:0] code);
        @(negedge clock);
        mode_wr = '1;
        mode_wdata = {`CIO_NPADS{code}};
        @(negedge clock);
        mode_wr = '0;
        cyc(2);
    endtask : set_all

    task automatic wr_out(input logic [`CIO_NPADS-1:0] v);
        @(negedge clock);
        out_wr = '1;
        out_wdata = v;
        @(negedge clock);
        out_wr = '0;
        cyc(2);
    endtask : wr_out

    // reset is asserted on a falling edge so the asynchronous clear sees a clean edge
    task automatic t_reset;
        @(negedge clock);
        resetn = 1'b0;
        cyc(10);
        chk("wake in reset", 2'h3, {pad_drv.oe[5], pad_drv.o[5]});
        cyc(10);
        resetn = 1'b1;
        cyc(4);
        chk("modes after reset", 18'h00000, mode_q);
        chk("oe after reset", 9'h000, pad_drv.oe);
    endtask : t_reset

    task automatic t_output;
        logic [8:0] v;
        set_all(`CIO_MODE_OUT);
        foreach (out_wdata[i])
        begin
            // shift at pad width so bits pushed past the top are dropped
            v = 9'h155 << i;
            wr_out(v);
            chk("out query", v, out_q);
            chk("out level", v, pad_i);
        end
        set_all(2'h3);
        chk("code 3 ignored", 18'h15555, mode_q);
    endtask : t_output

    task automatic t_input;
        set_all(`CIO_MODE_IN);
        ext_en = '1;
        foreach (ext_val[i])
        begin
            ext_val = 9'h0A5 ^ (9'h001 << i);
            cyc(7);
            chk("in level", 9'h0A5 ^ (9'h001 << i), in_level_q);
        end
        wr_out(9'h1FF);
        chk("input not driven", 9'h000, pad_drv.oe);
    endtask : t_input

    task automatic t_alt;
        int toggles;
        logic prev;
        toggles = 0;
        ext_en = 9'h00C;
        ext_val = 9'h00C;
        set_all(`CIO_MODE_ALT);
        {jam_detect, voice_out_data, voice_frame_sync, voice_clk} = 4'hF;
        wr_out(9'h000);
        chk("alt pads", 4'hF, {pad_i[0], pad_i[7], pad_i[1], pad_i[8]});
        jam_detect = 1'b0;
        cyc(7);
        chk("jam low", 2'h1, {pad_i[0], voice_in_data});
        alarm_start = 1'b1;
        cyc(1);
        alarm_start = 1'b0;
        cyc(20);
        chk("alarm held", 2'h3, {alarm_q, pad_i[5]});
        alarm_clear = 1'b1;
        cyc(1);
        alarm_clear = 1'b0;
        cyc(3);
        chk("alarm cleared", 2'h0, {alarm_q, pad_i[5]});
        tone_on = 1'b1;
        cyc(10);
        prev = pad_i[6];
        repeat (40)
        begin
            cyc(1);
            toggles += (pad_i[6] !== prev);
            prev = pad_i[6];
        end
        chk("tone toggles", 18'h0000A, 18'(toggles));
        ext_val[3] = 1'b0;
        cyc(7);
        chk("inhibit low", 1'b1, tx_inhibited);
        ext_val[3] = 1'b1;
        cyc(7);
        chk("inhibit high", 1'b0, tx_inhibited);
        tx_request = 1'b1;
        cyc(4);
        chk("monitor rise", 1'b1, pad_i[4]);
        cyc(100);
        chk("transmit waits lead", 1'b0, tx_enable_q);
        tx_request = 1'b0;
        cyc(100);
        chk("monitor trail", 1'b1, pad_i[4]);
    endtask : t_alt

    // main sequence
    initial
    begin
        // reset starts inactive and is asserted at the first falling edge
        resetn = 1'b1;
        {jam_detect, tx_request, alarm_start, alarm_clear, tone_on} = '0;
        {voice_out_data, voice_frame_sync, voice_clk, mode_wr, out_wr, out_wdata, ext_en, ext_val} = '0;
        mode_wdata = '0;
        tone_half = 16'h0004;
        t_reset();
        t_output();
        t_input();
        t_alt();
        give_verdict();
    end
endmodule : test_configurable_io_pad_modes
